/* hw/rtcs_dev.sv */
`timescale 1ns/10ps
`include "rtcs_params.svh"
module rtcs_dev
  import rtcs_pkg::*;
(
  input  wire logic mclk,
  input  wire logic resetn,
  rtcs_if.dev       lnk,
  input  wire logic timer_event,   // down-counter reached zero
  input  wire logic alarm_event,   // alarm match
  input  wire logic freq_wave,     // divided frequency output
  output logic      timer_flag,
  output logic      alarm_flag
);
  logic [7:0]     regs_reg [16];
  logic [2:0]     ce_s, ck_s, dt_s, mid_s;
  rtcs_phase_type phase_reg;
  logic [2:0]     bit_reg;
  logic [3:0]     hdr_cnt_reg, addr_reg, mode_reg;
  logic [7:0]     sh_reg, tcnt_reg;
  logic [25:0]    rtn_reg, hz_reg;
  logic           pulse_reg, hz_out_reg, dout_reg, doe_n_reg, irq_oe_n_reg;
  wire            ce_v = ce_s[1];
  wire            rise = ck_s[1] & ~ck_s[2];
  wire            din  = dt_s[1];
  wire [7:0]      ctrl = regs_reg[`RTCS_ADDR_CTRL1];
  wire            timer_irq_enable  = ctrl[`RTCS_BIT_TIE];
  wire            alarm_irq_enable  = ctrl[`RTCS_BIT_AIE];
  wire            fe   = ctrl[`RTCS_BIT_FE];
  wire            tp   = ctrl[`RTCS_BIT_TP];

  // two-stage sync; edge detect uses stages 1 and 2 only
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ce_s <= 3'h0; ck_s <= 3'h0; dt_s <= 3'h0; mid_s <= 3'h0;
    end else begin
      ce_s  <= {ce_s[1:0], lnk.ce};
      ck_s  <= {ck_s[1:0], lnk.sclk};
      dt_s  <= {dt_s[1:0], lnk.data_host};
      mid_s <= {mid_s[1:0], lnk.ce_mid};
    end
  end

  // frame decoder; ce low aborts the frame
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= RTCS_HDR; hdr_cnt_reg <= 4'h0; bit_reg <= 3'h0;
      addr_reg <= 4'h0; mode_reg <= 4'h0; sh_reg <= 8'h00;
    end else if (!ce_v) begin
      phase_reg <= RTCS_HDR; hdr_cnt_reg <= 4'h0; bit_reg <= 3'h0; // see [RULE_24] [RULE_06]
    end else if (rise) begin
      case (phase_reg)
        RTCS_HDR: begin // see [RULE_04]
          hdr_cnt_reg <= hdr_cnt_reg + 4'h1;
          if (hdr_cnt_reg < 4'h4) mode_reg <= {mode_reg[2:0], din};
          else addr_reg <= {addr_reg[2:0], din};
          if (hdr_cnt_reg == 4'h7) begin
            if (mode_reg == `RTCS_MODE_WRITE) phase_reg <= RTCS_WR; // see [RULE_08]
            else if (mode_reg == `RTCS_MODE_READ) phase_reg <= RTCS_RD; // see [RULE_10]
            else phase_reg <= RTCS_IGN; // see [RULE_13]
          end
        end
        RTCS_WR, RTCS_RD: begin
          sh_reg  <= {din, sh_reg[7:1]}; // lsb first, see [RULE_07]
          bit_reg <= bit_reg + 3'h1;
          if (bit_reg == 3'h7) addr_reg <= addr_reg + 4'h1; // wraps, see [RULE_09] [RULE_11] [RULE_12]
        end
        default: ;
      endcase
    end
  end

  wire wr_commit = ce_v & rise & (phase_reg == RTCS_WR) & (bit_reg == 3'h7);
  wire [7:0] wbyte = {din, sh_reg[7:1]};

  // register file and flags; hardware set wins over a zero write
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) regs_reg[i] <= 8'h00;
    end else begin
      if (wr_commit) begin
        if (addr_reg == `RTCS_ADDR_CTRL1) begin
          regs_reg[`RTCS_ADDR_CTRL1] <= {wbyte[7:4],
            ctrl[`RTCS_BIT_AF] & wbyte[`RTCS_BIT_AF], // see [RULE_22]
            ctrl[`RTCS_BIT_TF] & wbyte[`RTCS_BIT_TF], wbyte[1:0]};
        end else if (addr_reg == `RTCS_ADDR_AL_WDAY)
          regs_reg[addr_reg] <= wbyte & `RTCS_WDAY_MASK; // see [RULE_14] [RULE_15]
        else
          regs_reg[addr_reg] <= wbyte;
      end
      if (timer_event) regs_reg[`RTCS_ADDR_CTRL1][`RTCS_BIT_TF] <= 1'b1; // see [RULE_02]
      if (alarm_event) regs_reg[`RTCS_ADDR_CTRL1][`RTCS_BIT_AF] <= 1'b1;
    end
  end

  // periodic reload counter and auto-return timer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tcnt_reg <= 8'h00; rtn_reg <= 26'h0; pulse_reg <= 1'b0;
    end else begin
      if (timer_event && tp) tcnt_reg <= regs_reg[`RTCS_ADDR_TCNT]; // see [RULE_21]
      if (timer_event && tp && timer_irq_enable) begin
        pulse_reg <= 1'b1;
        case (regs_reg[`RTCS_ADDR_TSRC][1:0]) // see [RULE_03]
          2'h1:    rtn_reg <= 26'(`RTCS_RTN_64_CYC);
          2'h2:    rtn_reg <= 26'(`RTCS_RTN_1_CYC);
          default: rtn_reg <= 26'(`RTCS_RTN_FAST_CYC);
        endcase
      end else if (rtn_reg > 26'h1) rtn_reg <= rtn_reg - 26'h1;
      else pulse_reg <= 1'b0;
    end
  end

  // 1 hz monitor square wave
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hz_reg <= 26'h0; hz_out_reg <= 1'b0;
    end else if (hz_reg == 26'(`RTCS_HALF_SEC_CYC - 1)) begin
      hz_reg <= 26'h0; hz_out_reg <= ~hz_out_reg;
    end else hz_reg <= hz_reg + 26'h1;
  end

  // pin drivers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_oe_n_reg <= 1'b1; doe_n_reg <= 1'b1; dout_reg <= 1'b1;
    end else begin
      if (mid_s[1]) irq_oe_n_reg <= hz_out_reg; // see [RULE_19]
      else if (timer_irq_enable & ~alarm_irq_enable & ~fe) // see [RULE_18]
        irq_oe_n_reg <= tp ? ~pulse_reg : ~ctrl[`RTCS_BIT_TF]; // see [RULE_01] [RULE_20]
      else if (alarm_irq_enable & ~timer_irq_enable & ~fe) irq_oe_n_reg <= ~ctrl[`RTCS_BIT_AF];
      else if (fe & ~timer_irq_enable & ~alarm_irq_enable) irq_oe_n_reg <= freq_wave;
      else irq_oe_n_reg <= 1'b1;
      doe_n_reg <= ~(ce_v && phase_reg == RTCS_RD); // see [RULE_23]
      dout_reg  <= regs_reg[addr_reg][bit_reg]; // lsb first, see [RULE_07]
    end
  end

  assign lnk.irq_out_n_oe_n = irq_oe_n_reg;
  assign lnk.irq_out_n_o    = 1'b0;
  assign lnk.data_dev       = dout_reg;
  assign lnk.data_dev_oe_n  = doe_n_reg;
  assign timer_flag         = ctrl[`RTCS_BIT_TF];
  assign alarm_flag         = ctrl[`RTCS_BIT_AF];
endmodule : rtcs_dev

/* hw/rtcs_host.sv */
`timescale 1ns/10ps
`include "rtcs_params.svh"
module rtcs_host
  import rtcs_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  rtcs_if.host             lnk
);
  // cmd word: [3:0] mode, [7:4] addr, [10:8] byte count, [12] start, [13] ce_mid
  logic [31:0]   cmd_reg, wdata_reg, rdata_reg;
  rtcs_host_type st_reg;
  logic [5:0]    nbits_reg, idx_reg;
  logic [2:0]    div_reg;
  logic [1:0]    di_s;
  logic          ce_reg, ck_reg, dq_reg, oe_n_reg, rdy_reg;
  logic [31:0]   rd_reg;
  wire           acc = psel & penable;
  wire           wr  = acc & pwrite;

  // apb registers; start is ignored while busy
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cmd_reg <= 32'h0; wdata_reg <= 32'h0;
    end else if (wr && paddr == `RTCS_APB_CMD) cmd_reg <= pwdata;
    else if (wr && paddr == `RTCS_APB_WDATA) wdata_reg <= pwdata;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdy_reg <= 1'b0; rd_reg <= 32'h0;
    end else begin
      rdy_reg <= psel & ~rdy_reg;
      case (paddr)
        `RTCS_APB_CMD:    rd_reg <= cmd_reg;
        `RTCS_APB_WDATA:  rd_reg <= wdata_reg;
        `RTCS_APB_RDATA:  rd_reg <= rdata_reg;
        `RTCS_APB_STATUS: rd_reg <= {31'h0, st_reg != RTCS_IDLE};
        default:          rd_reg <= 32'h0;
      endcase
    end
  end

  // serial master: 8 header bits then up to seven bytes, lsb first
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= RTCS_IDLE; ce_reg <= 1'b0; ck_reg <= 1'b0; dq_reg <= 1'b0;
      oe_n_reg <= 1'b1; nbits_reg <= 6'h0; idx_reg <= 6'h0; div_reg <= 3'h0;
      rdata_reg <= 32'h0; di_s <= 2'h0;
    end else begin
      di_s <= {di_s[0], lnk.data_dev};
      case (st_reg)
        RTCS_IDLE: begin
          ce_reg <= 1'b0; oe_n_reg <= 1'b1;
          if (wr && paddr == `RTCS_APB_CMD && pwdata[12]) begin
            st_reg <= RTCS_SHIFT; ce_reg <= 1'b1; idx_reg <= 6'h0; div_reg <= 3'h0;
            rdata_reg <= 32'h0; // stale bytes of a longer earlier read must not show
            nbits_reg <= 6'(8 + 8 * pwdata[10:8]); // whole bytes only, see [RULE_05]
          end
        end
        RTCS_SHIFT: begin
          div_reg <= div_reg + 3'h1;
          if (div_reg == 3'h0 && !ck_reg) begin
            oe_n_reg <= (idx_reg >= 6'h8) && (cmd_reg[3:0] == `RTCS_MODE_READ);
            if (idx_reg < 6'h4) dq_reg <= cmd_reg[3 - idx_reg[1:0]]; // see [RULE_04] [RULE_08] [RULE_10]
            else if (idx_reg < 6'h8) dq_reg <= cmd_reg[7 - idx_reg[1:0]];
            else dq_reg <= wdata_reg[idx_reg[4:0] - 5'h8]; // see [RULE_07]
          end else if (div_reg == 3'h0 && ck_reg && idx_reg == 6'h7 &&
                       cmd_reg[3:0] == `RTCS_MODE_READ) begin
            // release right after the last header rise; the device needs 4 cycles to drive
            oe_n_reg <= 1'b1; // see [RULE_23]
          end else if (div_reg == 3'(`RTCS_HALF_BIT_CYC)) begin
            ck_reg <= ~ck_reg;
            div_reg <= 3'h0;
            if (ck_reg) begin
              idx_reg <= idx_reg + 6'h1;
              if (idx_reg + 6'h1 == nbits_reg) st_reg <= RTCS_DONE;
            end else if (idx_reg >= 6'h8)
              rdata_reg[idx_reg[4:0] - 5'h8] <= di_s[1];
          end
        end
        default: begin
          ce_reg <= 1'b0; oe_n_reg <= 1'b1; st_reg <= RTCS_IDLE; // see [RULE_24]
        end
      endcase
    end
  end

  assign prdata             = rd_reg;
  assign pready             = rdy_reg;
  assign pslverr            = 1'b0;
  assign lnk.ce             = ce_reg;
  assign lnk.ce_mid         = cmd_reg[13];
  assign lnk.sclk           = ck_reg;
  assign lnk.data_host      = dq_reg;
  assign lnk.data_host_oe_n = oe_n_reg;
endmodule : rtcs_host

/* hw/rtcs_if.sv */
`timescale 1ns/10ps
interface rtcs_if;
  logic ce;        // chip enable from host
  logic ce_mid;    // chip enable held at mid level
  logic sclk;      // host shift clock
  logic data_host; // host data out
  logic data_host_oe_n;
  logic data_dev;  // device data out
  logic data_dev_oe_n;
  logic irq_out_n_o;  // open drain: only low is driven
  logic irq_out_n_oe_n;
  modport host (output ce, ce_mid, sclk, data_host, data_host_oe_n,
                input data_dev, data_dev_oe_n, irq_out_n_o, irq_out_n_oe_n);
  modport dev (input ce, ce_mid, sclk, data_host, data_host_oe_n,
               output data_dev, data_dev_oe_n, irq_out_n_o, irq_out_n_oe_n);
endinterface : rtcs_if

/* hw/rtcs_params.svh */
`ifndef RTCS_PARAMS_SVH
`define RTCS_PARAMS_SVH
// Overview of operation
// [RULE_01] level mode: enabled timer event pulls pin low
// [RULE_02] periodic mode, enable clear: flag set, pin released
// [RULE_03] periodic low pulse self-releases after source-dependent time
// [RULE_04] four mode bits, four address bits, then bytes
// [RULE_05] host writes only whole bytes
// [RULE_06] partial write byte discarded at frame end
// [RULE_07] data bytes shifted lsb first
// [RULE_08] mode code 3 selects write
// [RULE_09] write stores at start address, then increments
// [RULE_10] mode code c selects read
// [RULE_11] read outputs start address, then increments
// [RULE_12] address wraps from f to 0
// [RULE_13] other mode codes ignored, data stays input
// [RULE_14] weekday alarm accepts several days at once
// [RULE_15] weekday bitmap bits 0..6, bit 7 excluded
// [RULE_16] host programs alarm in recommended order
// [RULE_17] polling host keeps alarm enable at zero
// [RULE_18] pin function chosen one-hot by three enables
// [RULE_19] mid-level chip enable gives 1 hz output
// [RULE_20] level mode pin stays low until flag cleared
// [RULE_21] periodic mode reloads counter at zero
// [RULE_22] flags clear on zero write, one ignored
// [RULE_23] read drives data only after header
// [RULE_24] chip enable fall aborts frame

// serial codes and register addresses
`define RTCS_MODE_WRITE   4'h3
`define RTCS_MODE_READ    4'hc
`define RTCS_ADDR_WDAY    4'h3
`define RTCS_ADDR_AL_WDAY 4'h9
`define RTCS_ADDR_FREQ    4'hb
`define RTCS_ADDR_TSRC    4'hc
`define RTCS_ADDR_TCNT    4'hd
`define RTCS_ADDR_CTRL1   4'he
// control register 1 fields
`define RTCS_BIT_TIE      0
`define RTCS_BIT_AIE      1
`define RTCS_BIT_TF       2
`define RTCS_BIT_AF       3
`define RTCS_BIT_TP       4
`define RTCS_BIT_FE       7
`define RTCS_WDAY_MASK    8'h7f
// timing at 10 mhz
`define RTCS_CLK_HZ       10000000
`define RTCS_RTN_FAST_NS  122000
`define RTCS_RTN_64_NS    7810000
`define RTCS_RTN_1_NS     500000000
`define RTCS_RTN_FAST_CYC (`RTCS_RTN_FAST_NS / 100)
`define RTCS_RTN_64_CYC   (`RTCS_RTN_64_NS / 100)
`define RTCS_RTN_1_CYC    (`RTCS_RTN_1_NS / 100)
`define RTCS_HALF_SEC_CYC (`RTCS_CLK_HZ / 2)
// apb offsets of the host controller
`define RTCS_APB_CMD      12'h000
`define RTCS_APB_WDATA    12'h004
`define RTCS_APB_RDATA    12'h008
`define RTCS_APB_STATUS   12'h00c
`define RTCS_HALF_BIT_CYC 4
`endif

/* hw/rtcs_pkg.sv */
package rtcs_pkg;
  typedef enum logic [1:0] {RTCS_HDR, RTCS_WR, RTCS_RD, RTCS_IGN} rtcs_phase_type;
  typedef enum logic [1:0] {RTCS_IDLE, RTCS_SHIFT, RTCS_DONE} rtcs_host_type;
endpackage : rtcs_pkg

/* sim/rtc_serial_port_and_irq_output_tb.sv */
`timescale 1ns/10ps
`include "rtcs_params.svh"
module rtc_serial_port_and_irq_output_tb;
  logic        mclk = 1'b0;
  logic        resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        timer_event, alarm_event, freq_wave, timer_flag, alarm_flag;
  int          errors = 0;
  int          checked = 0;

  always #50 mclk = ~mclk;

  rtcs_if lnk_if ();
  rtcs_host rtcs_host_i (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk_if));
  rtcs_dev rtcs_dev_i (.mclk(mclk), .resetn(resetn), .lnk(lnk_if), .timer_event(timer_event),
    .alarm_event(alarm_event), .freq_wave(freq_wave), .timer_flag(timer_flag),
    .alarm_flag(alarm_flag));
  rtcs_sva rtcs_sva_i (.mclk(mclk), .resetn(resetn), .ce(lnk_if.ce), .sclk(lnk_if.sclk),
    .data_host_oe_n(lnk_if.data_host_oe_n), .data_dev_oe_n(lnk_if.data_dev_oe_n),
    .irq_out_n_o(lnk_if.irq_out_n_o), .irq_out_n_oe_n(lnk_if.irq_out_n_oe_n),
    .timer_flag(timer_flag), .alarm_flag(alarm_flag));

  task summarize;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      summarize();
    end
    @(posedge mclk);
  endtask : apb

  // one serial frame: header, then 1+extra bytes, wait while busy
  task frame(input logic [3:0] mode, input logic [3:0] a, input logic [2:0] extra,
             input logic [31:0] d);
    int n;
    apb(1'b1, `RTCS_APB_WDATA, d);
    // the count field gives the number of data bytes, so one more than extra
    apb(1'b1, `RTCS_APB_CMD, {19'h0, 1'b1, 1'b0, 3'(extra + 3'h1), a, mode});
    repeat (2) @(posedge mclk);
    n = 0;
    do begin
      apb(1'b0, `RTCS_APB_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 2000);
    if (rd[0] !== 1'b0) begin
      errors++;
      summarize();
    end
  endtask : frame

  task rdchk(input logic [3:0] a, input logic [2:0] extra, input logic [31:0] exp);
    frame(`RTCS_MODE_READ, a, extra, 32'h0);
    apb(1'b0, `RTCS_APB_RDATA, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // one-cycle event pulse, then let the pin settle
  task tick(input logic tmr);
    timer_event <= tmr;
    alarm_event <= ~tmr;
    @(posedge mclk);
    timer_event <= 1'b0;
    alarm_event <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : tick

  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    timer_event = 1'b0;
    alarm_event = 1'b0;
    freq_wave = 1'b0; // frequency path left idle, pin never in that mode here
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    frame(`RTCS_MODE_WRITE, 4'hf, 3'h1, 32'h0000_3502);
    rdchk(4'hf, 3'h1, 32'h0000_3502);
    frame(`RTCS_MODE_WRITE, `RTCS_ADDR_AL_WDAY, 3'h0, 32'h0000_00ff);
    rdchk(`RTCS_ADDR_AL_WDAY, 3'h0, 32'h0000_007f);
    frame(4'h5, `RTCS_ADDR_AL_WDAY, 3'h0, 32'h0000_003e);
    rdchk(`RTCS_ADDR_AL_WDAY, 3'h0, 32'h0000_007f);
    // level mode: pin low until a zero is written to the flag
    frame(`RTCS_MODE_WRITE, `RTCS_ADDR_CTRL1, 3'h0, 32'h0000_0001);
    tick(1'b1);
    chk({30'h0, lnk_if.irq_out_n_oe_n, timer_flag}, 32'h1);
    frame(`RTCS_MODE_WRITE, `RTCS_ADDR_CTRL1, 3'h0, 32'h0000_0005);
    chk({30'h0, lnk_if.irq_out_n_oe_n, timer_flag}, 32'h1);
    frame(`RTCS_MODE_WRITE, `RTCS_ADDR_CTRL1, 3'h0, 32'h0000_0001);
    chk({30'h0, lnk_if.irq_out_n_oe_n, timer_flag}, 32'h2);
    // periodic mode with enable clear: flag only
    frame(`RTCS_MODE_WRITE, `RTCS_ADDR_CTRL1, 3'h0, 32'h0000_0010);
    tick(1'b1);
    chk({30'h0, lnk_if.irq_out_n_oe_n, timer_flag}, 32'h3);
    // alarm function alone on the pin
    frame(`RTCS_MODE_WRITE, `RTCS_ADDR_CTRL1, 3'h0, 32'h0000_0002);
    tick(1'b0);
    chk({30'h0, lnk_if.irq_out_n_oe_n, alarm_flag}, 32'h1);
    frame(`RTCS_MODE_WRITE, `RTCS_ADDR_CTRL1, 3'h0, 32'h0000_0000);
    chk({30'h0, lnk_if.irq_out_n_oe_n, alarm_flag}, 32'h2);
    summarize();
  end
endmodule : rtc_serial_port_and_irq_output_tb

/* sim/rtcs_sva.sv */
`timescale 1ns/10ps
module rtcs_sva (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic sclk,
  input wire logic data_host_oe_n,
  input wire logic data_dev_oe_n,
  input wire logic irq_out_n_o,
  input wire logic irq_out_n_oe_n,
  input wire logic timer_flag,
  input wire logic alarm_flag
);
  logic       sclk_reg;
  logic [7:0] bits_reg;
  logic [3:0] idle_reg;

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // raw sclk rises per frame; runs ahead of the device's synchroniser, so header checks are safe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sclk_reg <= 1'b0;
      bits_reg <= 8'h00;
    end else begin
      sclk_reg <= sclk;
      bits_reg <= ce ? bits_reg + {7'h00, sclk & ~sclk_reg} : 8'h00;
    end
  end

  // cycles since the last frame; flags may only clear through a write
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) idle_reg <= 4'hf;
    else if (ce) idle_reg <= 4'h0;
    else if (idle_reg != 4'hf) idle_reg <= idle_reg + 4'h1;
  end

  sequence frame_end;
    $fell(ce);
  endsequence

  sequence hdr_bit;
    ce && sclk && !sclk_reg && bits_reg < 8'h08;
  endsequence

  whole_bytes_a: assert property (frame_end |-> bits_reg >= 8'h08 && bits_reg[2:0] == 3'h0)
    else $error("frame ended inside a byte");
  dev_release_a: assert property (frame_end |-> ##[0:6] data_dev_oe_n)
    else $error("device kept data line after frame end");
  hdr_quiet_a: assert property (ce && bits_reg < 8'h08 |-> data_dev_oe_n)
    else $error("device drove data during header");
  hdr_drive_a: assert property (hdr_bit |-> !data_host_oe_n)
    else $error("host not driving a header bit");
  bus_fight_a: assert property (!(!data_dev_oe_n && !data_host_oe_n))
    else $error("both ends drive data");
  irq_drive_a: assert property (!irq_out_n_oe_n |-> !irq_out_n_o)
    else $error("irq pin driven high");
  tflag_hold_a: assert property ($fell(timer_flag) |-> idle_reg < 4'h8)
    else $error("timer flag cleared without a write");
  aflag_hold_a: assert property ($fell(alarm_flag) |-> idle_reg < 4'h8)
    else $error("alarm flag cleared without a write");
endmodule : rtcs_sva
